// file: pmusi_bank.sv
// Regulator power-good and primary event status/mask register bank
`include "pmusi_params.svh"
`default_nettype none

// Summary of operation
// R1 - Regulator status bits 7-6 read zero
// R2 - Bits 0-5 follow regulators 5-10 power-good
// R3 - Power-good invalid when supply below 1V; no supply sense here, validity left to software
// R4 - Regulator status at 38h, read-only, resets zero
// R5 - Power-on reset clears both status registers
// R6 - Event status at 39h resets zero, sticky
// R7 - Write one clears flag, zero keeps
// R8 - Pin1 fall sets bit7, rise bit6
// R9 - Over-temperature warning sets bit 5
// R10 - Hold pin rise bit4, fall bit0
// R11 - Button press bit2, long press bit3
// R12 - Supply below threshold sets bit1 on the third clock after the comparator changes
// R13 - Mask at 3Ah, set bit suppresses interrupt
// R14 - Interrupt high while unmasked flag set
module pmusi_bank (
	input  wire logic                      mclk,
	input  wire logic                      rst_n,
	input  wire logic                      ce,
	input  wire logic [`PMUSI_ADDR_W-1:0]  reg_addr,
	input  wire logic [`PMUSI_DATA_W-1:0]  reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic      [`PMUSI_DATA_W-1:0]  reg_rdata,
	input  wire logic                      reg5_in_regulation,
	input  wire logic                      reg6_in_regulation,
	input  wire logic                      reg7_in_regulation,
	input  wire logic                      reg8_in_regulation,
	input  wire logic                      reg9_in_regulation,
	input  wire logic                      reg10_in_regulation,
	input  wire logic                      gpio1_pin,
	input  wire logic                      overtemp_warn,
	input  wire logic                      power_hold_pin,
	input  wire logic                      button_press_evt,
	input  wire logic                      button_long_press_evt,
	input  wire logic                      supply_monitor_input,
	output logic      [1:0]                monitor_threshold_select,
	output logic                           irq
);
	localparam int NPIN = 6;

	// Pin map into the synchroniser vector
	localparam int P_GPIO  = 0;
	localparam int P_HOT   = 1;
	localparam int P_HOLD  = 2;
	localparam int P_PRESS = 3;
	localparam int P_LONG  = 4;
	localparam int P_MON   = 5;

	logic [NPIN-1:0]                pin_raw;
	logic [NPIN-1:0]                pin_rise;
	logic [NPIN-1:0]                pin_fall;
	logic [`PMUSI_PG_COUNT-1:0]     pg_raw;
	logic [`PMUSI_PG_COUNT-1:0]     pg_lvl;
	logic [`PMUSI_PG_COUNT-1:0]     pg_q;
	pmusi_pkg::pmusi_byte_t         evt_set;
	pmusi_pkg::pmusi_byte_t         evt_clr;
	pmusi_pkg::pmusi_byte_t         evt_flags;
	pmusi_pkg::pmusi_byte_t         mask_q;
	pmusi_pkg::pmusi_byte_t         mask_d;
	logic [1:0]                     mon_cfg_q;
	logic [1:0]                     mon_cfg_d;
	pmusi_pkg::pmusi_byte_t         rdata_q;
	pmusi_pkg::pmusi_byte_t         rdata_d;
	logic                           irq_q;
	logic                           irq_d;
	pmusi_pkg::pmusi_sel_t          rd_sel;
	logic                           wr_sts;
	logic                           wr_mask;
	logic                           wr_cfg;
	logic                           hit_cfg;

	function automatic pmusi_pkg::pmusi_sel_t decode_sel(input logic [`PMUSI_ADDR_W-1:0] a);
		pmusi_pkg::pmusi_sel_t s;
		s = pmusi_pkg::PMUSI_SEL_NONE;
		if (a == `PMUSI_OFS_PGOOD_HI)
			s = pmusi_pkg::PMUSI_SEL_PG;
		else if (a == `PMUSI_OFS_EVT_STS)
			s = pmusi_pkg::PMUSI_SEL_STS;
		else if (a == `PMUSI_OFS_EVT_MASK)
			s = pmusi_pkg::PMUSI_SEL_MASK;
		return s;
	endfunction : decode_sel

	assign pin_raw = {supply_monitor_input, button_long_press_evt, button_press_evt,
	                  power_hold_pin, overtemp_warn, gpio1_pin};
	assign pg_raw  = {reg10_in_regulation, reg9_in_regulation, reg8_in_regulation,
	                  reg7_in_regulation, reg6_in_regulation, reg5_in_regulation};

	// Comparator outputs are asynchronous to mclk
	pmusi_sync_edge #(
		.WIDTH (NPIN)
	) u_pin_sync (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.ce       (ce),
		.async_in (pin_raw),
		.level    (),
		.rise     (pin_rise),
		.fall     (pin_fall)
	);

	pmusi_sync_edge #(
		.WIDTH (`PMUSI_PG_COUNT)
	) u_pg_sync (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.ce       (ce),
		.async_in (pg_raw),
		.level    (pg_lvl),
		.rise     (),
		.fall     ()
	);

	// R2 live power-good mirror
	// R3 validity left to software; no supply sense here
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			pg_q <= '0;
		else if (ce)
			pg_q <= pg_lvl;
	end

	assign rd_sel  = decode_sel(reg_addr);
	assign hit_cfg = (reg_addr == `PMUSI_OFS_MON_CFG);
	// R4 read-only register: writes at 38h have no effect
	assign wr_sts  = reg_wr && (rd_sel == pmusi_pkg::PMUSI_SEL_STS);
	assign wr_mask = reg_wr && (rd_sel == pmusi_pkg::PMUSI_SEL_MASK);
	assign wr_cfg  = reg_wr && hit_cfg;

	// R8 pin-one edges
	assign evt_set[`PMUSI_BIT_PIN1_FALL]  = pin_fall[P_GPIO];
	assign evt_set[`PMUSI_BIT_PIN1_RISE]  = pin_rise[P_GPIO];
	// R9 over-temperature onset
	assign evt_set[`PMUSI_BIT_OVERTEMP]   = pin_rise[P_HOT];
	// R10 hold pin edges
	assign evt_set[`PMUSI_BIT_HOLD_RISE]  = pin_rise[P_HOLD];
	assign evt_set[`PMUSI_BIT_HOLD_FALL]  = pin_fall[P_HOLD];
	// R11 button detector events
	assign evt_set[`PMUSI_BIT_LONG_PRESS] = pin_rise[P_LONG];
	assign evt_set[`PMUSI_BIT_PRESS]      = pin_rise[P_PRESS];
	// R12 comparator falling below threshold, no filter
	assign evt_set[`PMUSI_BIT_SUPPLY_MON] = pin_rise[P_MON];

	// R7 write one clears, zero keeps
	assign evt_clr = wr_sts ? reg_wdata : 8'h00;

	// R6 sticky flags, reset to zero
	// R5 cleared on power-on reset
	pmusi_flag_bank #(
		.WIDTH (`PMUSI_DATA_W)
	) u_flags (
		.mclk  (mclk),
		.rst_n (rst_n),
		.ce    (ce),
		.set   (evt_set),
		.clr   (evt_clr),
		.flags (evt_flags)
	);

	assign mask_d    = wr_mask ? reg_wdata : mask_q;
	assign mon_cfg_d = wr_cfg ? reg_wdata[1:0] : mon_cfg_q;

	// R1 reserved bits forced to zero on read
	assign rdata_d = !reg_rd ? 8'h00 :
	                 (rd_sel == pmusi_pkg::PMUSI_SEL_PG)   ? {`PMUSI_PG_RSVD_VAL, pg_q} :
	                 (rd_sel == pmusi_pkg::PMUSI_SEL_STS)  ? evt_flags :
	                 (rd_sel == pmusi_pkg::PMUSI_SEL_MASK) ? mask_q :
	                 hit_cfg ? {6'h00, mon_cfg_q} : 8'h00;

	// R13 set mask bit suppresses
	// R14 level interrupt from unmasked flags
	assign irq_d = |(evt_flags & ~mask_q);

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			mask_q    <= `PMUSI_EVT_MASK_RST;
			mon_cfg_q <= `PMUSI_MON_CFG_RST;
			rdata_q   <= 8'h00;
			irq_q     <= 1'b0;
		end
		else if (ce)
		begin
			mask_q    <= mask_d;
			mon_cfg_q <= mon_cfg_d;
			rdata_q   <= rdata_d;
			irq_q     <= irq_d;
		end
	end

	assign reg_rdata                = rdata_q;
	assign irq                      = irq_q;
	assign monitor_threshold_select = mon_cfg_q;
endmodule : pmusi_bank
`default_nettype wire

// file: pmusi_params.svh
// Register offsets, field positions and reset values of the status/interrupt bank
`ifndef PMUSI_PARAMS_SVH
`define PMUSI_PARAMS_SVH

`define PMUSI_ADDR_W          8
`define PMUSI_DATA_W          8
`define PMUSI_OFS_PGOOD_HI    8'h38
`define PMUSI_OFS_EVT_STS     8'h39
`define PMUSI_OFS_EVT_MASK    8'h3A
`define PMUSI_OFS_MON_CFG     8'h3E
`define PMUSI_PG_COUNT        6
`define PMUSI_PG_RSVD_VAL     2'h0
`define PMUSI_EVT_STS_RST     8'h00
`define PMUSI_EVT_MASK_RST    8'hFF
`define PMUSI_MON_CFG_RST     2'h0
`define PMUSI_BIT_PIN1_FALL   7
`define PMUSI_BIT_PIN1_RISE   6
`define PMUSI_BIT_OVERTEMP    5
`define PMUSI_BIT_HOLD_RISE   4
`define PMUSI_BIT_LONG_PRESS  3
`define PMUSI_BIT_PRESS       2
`define PMUSI_BIT_SUPPLY_MON  1
`define PMUSI_BIT_HOLD_FALL   0

`endif

// file: pmusi_pkg.sv
// Types shared by the status/interrupt bank
`default_nettype none
package pmusi_pkg;
	typedef logic [7:0] pmusi_byte_t;
	typedef enum logic [1:0]
	{
		PMUSI_SEL_NONE  = 2'b00,
		PMUSI_SEL_PG    = 2'b01,
		PMUSI_SEL_STS   = 2'b10,
		PMUSI_SEL_MASK  = 2'b11
	} pmusi_sel_t;
endpackage : pmusi_pkg
`default_nettype wire

// file: pmusi_sync_edge.sv
// Two-flop synchroniser with rise and fall pulse outputs
`default_nettype none
module pmusi_sync_edge #(
	parameter int WIDTH = 1
) (
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise,
	output logic      [WIDTH-1:0] fall
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] prev_q;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
		end
		else if (ce)
		begin
			meta_q <= async_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// Edges qualified by ce so a frozen block sees no stale pulse
	assign level = sync_q;
	assign rise  = {WIDTH{ce}} & sync_q & ~prev_q;
	assign fall  = {WIDTH{ce}} & ~sync_q & prev_q;
endmodule : pmusi_sync_edge
`default_nettype wire

// file: pmusi_flag_bank.sv
// Sticky write-one-to-clear flags with set priority
`default_nettype none
module pmusi_flag_bank #(
	parameter int WIDTH = 8
) (
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] set,
	input  wire logic [WIDTH-1:0] clr,
	output logic      [WIDTH-1:0] flags
);
	logic [WIDTH-1:0] flags_q;
	logic [WIDTH-1:0] flags_d;

	// Set wins over a clear in the same cycle
	assign flags_d = set | (flags_q & ~clr);
	assign flags   = flags_q;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			flags_q <= '0;
		else if (ce)
			flags_q <= flags_d;
	end
endmodule : pmusi_flag_bank
`default_nettype wire

// file: pmusi_bank_chk.sv
// Port-level assertions for the status/interrupt register bank
`include "pmusi_params.svh"
`default_nettype none
module pmusi_bank_chk (
	input wire logic       mclk,
	input wire logic       rst_n,
	input wire logic       ce,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg5_in_regulation,
	input wire logic       reg6_in_regulation,
	input wire logic       reg7_in_regulation,
	input wire logic       reg8_in_regulation,
	input wire logic       reg9_in_regulation,
	input wire logic       reg10_in_regulation,
	input wire logic [1:0] monitor_threshold_select,
	input wire logic       irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	wire logic [5:0] pg_vec;
	wire logic       rd_go;
	wire logic       wr_go;
	assign pg_vec = {reg10_in_regulation, reg9_in_regulation, reg8_in_regulation,
		reg7_in_regulation, reg6_in_regulation, reg5_in_regulation};
	assign rd_go = ce && reg_rd;
	assign wr_go = ce && reg_wr;
	// Five quiet cycles cover the synchroniser delay
	sequence s_pg_steady;
		(rst_n && ce && $stable(pg_vec)) [*5];
	endsequence
	sequence s_mask_wr;
		wr_go && reg_addr == `PMUSI_OFS_EVT_MASK;
	endsequence
	property p_rsvd;
		rd_go && reg_addr == `PMUSI_OFS_PGOOD_HI |=> reg_rdata[7:6] == `PMUSI_PG_RSVD_VAL;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
	property p_pg_follow;
		s_pg_steady ##0 (rd_go && reg_addr == `PMUSI_OFS_PGOOD_HI) |=> reg_rdata[5:0] == $past(pg_vec);
	endproperty
	a_pg_follow: assert property (p_pg_follow) else $error("power-good bits wrong");
	property p_idle;
		ce && !reg_rd |=> reg_rdata == 8'h00;
	endproperty
	a_idle: assert property (p_idle) else $error("read data without read");
	property p_reset;
		$rose(rst_n) |-> reg_rdata == 8'h00 && !irq && monitor_threshold_select == 2'h0;
	endproperty
	a_reset: assert property (p_reset) else $error("outputs not reset");
	property p_mask_irq;
		s_mask_wr ##0 reg_wdata == 8'hFF ##1 ce |=> !irq;
	endproperty
	a_mask_irq: assert property (p_mask_irq) else $error("irq despite full mask");
	property p_mask_back;
		s_mask_wr ##1 !wr_go ##1 (rd_go && reg_addr == `PMUSI_OFS_EVT_MASK) |=> reg_rdata == $past(reg_wdata, 3);
	endproperty
	a_mask_back: assert property (p_mask_back) else $error("mask readback wrong");
	property p_cfg;
		wr_go && reg_addr == `PMUSI_OFS_MON_CFG |=> {6'h00, monitor_threshold_select} == ($past(reg_wdata) & 8'h03);
	endproperty
	a_cfg: assert property (p_cfg) else $error("threshold select not written");
	property p_irq_quiet;
		rd_go && reg_addr == `PMUSI_OFS_EVT_STS ##1 reg_rdata == 8'h00 |-> !irq;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("irq with no flags");
endmodule : pmusi_bank_chk
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the status/interrupt register bank
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       mclk = 1'b0;
	logic       rst_n = 1'b0;
	logic       ce = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [5:0] pg = 6'h00;
	logic [5:0] src = 6'h00;
	logic [1:0] sel;
	logic       irq;
	int         mismatches = 0;
	int         checked = 0;
	int         step_bit[8] = '{0, 1, 2, 3, 4, 5, 0, 2};
	logic [7:0] step_sts[8] = '{8'h40, 8'h60, 8'h70, 8'h74, 8'h7C, 8'h7E, 8'hFE, 8'hFF};
	logic [5:0] pg_pat[3] = '{6'h2A, 6'h15, 6'h3F};
	pmusi_bank i_dut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg5_in_regulation(pg[0]),
		.reg6_in_regulation(pg[1]), .reg7_in_regulation(pg[2]), .reg8_in_regulation(pg[3]),
		.reg9_in_regulation(pg[4]), .reg10_in_regulation(pg[5]), .gpio1_pin(src[0]), .overtemp_warn(src[1]),
		.power_hold_pin(src[2]), .button_press_evt(src[3]), .button_long_press_evt(src[4]),
		.supply_monitor_input(src[5]), .monitor_threshold_select(sel), .irq(irq));
	initial
	begin
		forever #2 mclk = ~mclk;
	end
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Tasks are entered just after a rising edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
		// Idle cycle keeps the next strobe out of this time step
		@(posedge mclk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		// Data launched at the previous edge still stands here
		@(posedge mclk);
		chk($sformatf("reg %h", a), e, reg_rdata);
	endtask : rd
	task automatic do_reset;
		rst_n <= 1'b0;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
	endtask : do_reset
	task automatic t_reset_vals;
		rd(8'h38, 8'h00);
		rd(8'h39, 8'h00);
		rd(8'h3A, 8'hFF);
		rd(8'h3E, 8'h00);
		chk("irq", 8'h00, {7'h00, irq});
	endtask : t_reset_vals
	task automatic t_power_good;
		foreach (pg_pat[i])
		begin
			pg <= pg_pat[i];
			repeat (4) @(posedge mclk);
			wr(8'h38, 8'hFF);
			rd(8'h38, {2'h0, pg_pat[i]});
		end
	endtask : t_power_good
	task automatic t_events;
		wr(8'h3A, 8'h00);
		rd(8'h3A, 8'h00);
		foreach (step_bit[i])
		begin
			src[step_bit[i]] <= ~src[step_bit[i]];
			repeat (5) @(posedge mclk);
			rd(8'h39, step_sts[i]);
		end
		chk("irq", 8'h01, {7'h00, irq});
		wr(8'h3A, 8'hFF);
		wr(8'h3A, 8'h00);
		wr(8'h39, 8'h0F);
		rd(8'h39, 8'hF0);
		wr(8'h39, 8'hF0);
		@(posedge mclk);
		chk("irq", 8'h00, {7'h00, irq});
		src <= 6'h00;
		repeat (5) @(posedge mclk);
		rd(8'h39, 8'h00);
	endtask : t_events
	task automatic t_misc;
		wr(8'h3E, 8'h03);
		rd(8'h3E, 8'h03);
		chk("sel", 8'h03, {6'h00, sel});
		// Write while frozen must be lost
		ce <= 1'b0;
		wr(8'h3E, 8'h01);
		ce <= 1'b1;
		rd(8'h3E, 8'h03);
		wr(8'h3B, 8'hFF);
		rd(8'h3B, 8'h00);
		src <= 6'h01;
		repeat (5) @(posedge mclk);
		rd(8'h39, 8'h40);
		do_reset;
		rd(8'h38, 8'h00);
		rd(8'h39, 8'h00);
		rd(8'h3A, 8'hFF);
	endtask : t_misc
	task automatic tally_and_finish;
		if (mismatches == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		do_reset;
		t_reset_vals;
		t_power_good;
		t_events;
		t_misc;
		tally_and_finish;
	end
	initial
	begin
		#20000;
		mismatches++;
		tally_and_finish;
	end
endmodule : tb_top
bind pmusi_bank pmusi_bank_chk i_chk (.*);
`default_nettype wire
